// ---- rbs_pkg.sv ----
// constants and carrier types for the reset, boot-strap and port-default block
//
// Overview of operation
// - each port pin picks one of four drivers from bit n of two select registers
// - select pair {b,a}: 00 open drain, 01 quasi, 10 off, 11 push-pull
// - after any reset all pins default to quasi-bidirectional
// - code-source strap low at reset makes data bus pins push-pull
// - bus width 8 or 16 bits from reset; address size 12 to 20 by software
// - external-only code starts fetching with the full 20-bit address size
// - reset input low reinitialises logic; board holds it at least 10 us
// - reset release raises exception and jumps via 16-bit vector at 0000
// - ram contents after reset are undefined; nothing clears them
// - code-source strap sampled on reset rising edge; high internal, low external
// - after reset the code-source strap pin serves as the bus wait input
// - bus-width strap weakly pulled high in reset; 1 is 16-bit, 0 is 8-bit
// - software may overwrite the latched bus width
// - idle stops the processor, peripherals run, their interrupt wakes it; here any low external interrupt pin wakes it
// - power-down stops the oscillator; exit by reset or external interrupt
// - external interrupt wakes power-down only if enabled and level-sensitive
// - power-down keeps ram, registers and special registers unchanged
package rbs_pkg;
    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 12;
    // drive select pair {b,a}
    localparam logic [1:0] DRV_OPEN_DRAIN = 2'h0;
    localparam logic [1:0] DRV_QUASI = 2'h1;
    localparam logic [1:0] DRV_OFF = 2'h2;
    localparam logic [1:0] DRV_PUSH_PULL = 2'h3;
    localparam logic [PORT_W-1:0] SEL_A_RESET = 8'hff;
    localparam logic [PORT_W-1:0] SEL_B_RESET = 8'h00;
    localparam logic [PORT_W-1:0] SEL_ALL = 8'hff;
    // ports carrying the external data bus (low and high byte)
    localparam int DATA_PORT_LO = 0;
    localparam int DATA_PORT_HI = 2;
    // address size field: 12..20 bits
    localparam logic [4:0] ADDR_SIZE_MIN = 5'h0c;
    localparam logic [4:0] ADDR_SIZE_MAX = 5'h14;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
    // timing, 10 MHz clock
    localparam int CLK_HZ = 10_000_000;
    localparam int RST_MIN_NS = 10_000;
    localparam int RST_MIN_CYC = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int STRAP_HOLD_CYC = 3;
    localparam logic [1:0] STRAP_HOLD_CNT = 2'(STRAP_HOLD_CYC - 1);
    // apb map
    localparam logic [ADDR_W-1:0] OFF_SEL_A0 = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_SEL_B0 = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_BUS_CFG = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_PWR_CTRL = 12'h024;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h028;
    localparam logic [ADDR_W-1:0] OFF_INT_CFG = 12'h02c;
    // bus config bits
    localparam int BC_WIDE = 0;
    localparam int BC_ASZ_LSB = 8;
    // power control bits
    localparam int PC_IDLE = 0;
    localparam int PC_PDOWN = 1;
    // status bits
    localparam int ST_EXT_CODE = 0;
    localparam int ST_WIDE_STRAP = 1;
    localparam int ST_IDLE = 2;
    localparam int ST_PDOWN = 3;
    localparam int ST_BOOT = 4;
    // interrupt config bits
    localparam int IC_EN0 = 0;
    localparam int IC_LVL0 = 2;

    typedef enum logic [2:0] {
        RBS_RESET, RBS_STRAP, RBS_BOOT, RBS_RUN, RBS_IDLE, RBS_PDOWN
    } rbs_state_t;

    typedef struct packed {
        logic ext_code;
        logic bus_wide;
        logic [4:0] addr_size;
        logic cpu_run;
        logic osc_run;
        logic boot_req;
        logic [15:0] boot_vector_addr;
        logic bus_wait;
    } rbs_core_t;
endpackage : rbs_pkg

// ---- rbs_sync.sv ----
// three-flop synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module rbs_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // asynchronous level in, settled level out
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic [2:0] sh;
        logic q;
    } rbs_sync_st_t;
    rbs_sync_st_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        st_next.sh = {st_reg.sh[1:0], din};
        // stage 0 only feeds stage 1
        if (st_reg.sh[1] == st_reg.sh[2]) begin
            st_next.q = st_reg.sh[2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.q;
endmodule : rbs_sync

// ---- rbs_drive_decode.sv ----
// decodes one port's select pair into per-pin driver controls
`timescale 1ns/1ps
module rbs_drive_decode (
    // select registers
    input wire logic [7:0] sel_a,
    input wire logic [7:0] sel_b,
    // per-pin driver mode
    output logic [7:0] open_drain,
    output logic [7:0] quasi,
    output logic [7:0] hi_z,
    output logic [7:0] push_pull
);
    function automatic logic [3:0] rbs_decode(input logic [1:0] pair);
        logic [3:0] d;
        d = 4'h0;
        case (pair)
            rbs_pkg::DRV_OPEN_DRAIN: d = 4'h1;
            rbs_pkg::DRV_QUASI: d = 4'h2;
            rbs_pkg::DRV_OFF: d = 4'h4;
            default: d = 4'h8;
        endcase
        return d;
    endfunction : rbs_decode

    for (genvar i = 0; i < rbs_pkg::PORT_W; i++) begin : g_pin
        logic [3:0] d;
        assign d = rbs_decode({sel_b[i], sel_a[i]});
        assign open_drain[i] = d[0];
        assign quasi[i] = d[1];
        assign hi_z[i] = d[2];
        assign push_pull[i] = d[3];
    end
endmodule : rbs_drive_decode

// ---- rbs_top.sv ----
// reset sequencing, strap capture, port driver defaults and power modes
`timescale 1ns/1ps
module rbs_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // board reset pin, active low, asynchronous to pclk
    input wire logic rst_pin_n,
    // strap pins
    input wire logic code_source_strap,
    input wire logic bus_width_strap,
    output logic bus_width_pull_up,
    // external interrupt pins
    input wire logic [1:0] ext_int_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rbs_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core side
    output rbs_pkg::rbs_core_t core,
    output logic logic_reset_n,
    output logic periph_run,
    // port drivers, one byte of pins per port
    output logic [rbs_pkg::NUM_PORTS*8-1:0] pin_open_drain,
    output logic [rbs_pkg::NUM_PORTS*8-1:0] pin_quasi,
    output logic [rbs_pkg::NUM_PORTS*8-1:0] pin_hi_z,
    output logic [rbs_pkg::NUM_PORTS*8-1:0] pin_push_pull
);
    localparam int NP = rbs_pkg::NUM_PORTS;
    localparam int PW = rbs_pkg::PORT_W;

    typedef struct packed {
        rbs_pkg::rbs_state_t state;
        logic [1:0] hold_cnt;
        logic ext_code;
        logic wide_strap;
        logic bus_wide;
        logic [4:0] addr_size;
        logic [NP-1:0][PW-1:0] sel_a;
        logic [NP-1:0][PW-1:0] sel_b;
        logic [3:0] int_cfg;
        logic boot_req;
        logic [31:0] rdata;
    } rbs_st_t;

    rbs_st_t st_reg, st_next;
    logic rst_sync;
    logic strap_cs_s;
    logic strap_bw_s;
    logic [1:0] eint_s;
    logic wr_en;
    logic rd_en;
    logic wake_int;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    rbs_sync u_sync_rst (.pclk(pclk), .presetn(presetn), .din(rst_pin_n), .dout(rst_sync));
    rbs_sync u_sync_cs (.pclk(pclk), .presetn(presetn), .din(code_source_strap), .dout(strap_cs_s));
    rbs_sync u_sync_bw (.pclk(pclk), .presetn(presetn), .din(bus_width_strap), .dout(strap_bw_s));
    for (genvar k = 0; k < 2; k++) begin : g_eint
        rbs_sync u_sync_ei (.pclk(pclk), .presetn(presetn), .din(ext_int_n[k]), .dout(eint_s[k]));
    end

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    function automatic logic map_hit(input logic [rbs_pkg::ADDR_W-1:0] a);
        logic h;
        h = 1'b0;
        if (a >= rbs_pkg::OFF_SEL_A0 && a < rbs_pkg::OFF_BUS_CFG) begin
            h = (a[1:0] == 2'h0);
        end else if (a == rbs_pkg::OFF_BUS_CFG || a == rbs_pkg::OFF_PWR_CTRL) begin
            h = 1'b1;
        end else if (a == rbs_pkg::OFF_STATUS || a == rbs_pkg::OFF_INT_CFG) begin
            h = 1'b1;
        end
        return h;
    endfunction : map_hit

    // power-down woken only by an enabled, level-sensitive external interrupt held low
    always_comb begin
        wake_int = 1'b0;
        for (int k = 0; k < 2; k++) begin
            if (st_reg.int_cfg[rbs_pkg::IC_EN0 + k] && st_reg.int_cfg[rbs_pkg::IC_LVL0 + k] && !eint_s[k]) begin
                wake_int = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] idx;
        idx = 3'h0;
        st_next = st_reg;
        st_next.boot_req = 1'b0;
        case (st_reg.state)
            rbs_pkg::RBS_RESET: begin
                // hold everything at defaults while the pin is low
                st_next.wide_strap = 1'b1;
                if (rst_sync) begin
                    st_next.state = rbs_pkg::RBS_STRAP;
                    st_next.hold_cnt = '0;
                    st_next.ext_code = ~strap_cs_s;
                    st_next.wide_strap = strap_bw_s;
                end
            end
            rbs_pkg::RBS_STRAP: begin
                // straps held three clocks after release, latch defaults at the end
                st_next.hold_cnt = st_reg.hold_cnt + 2'h1;
                if (st_reg.hold_cnt == rbs_pkg::STRAP_HOLD_CNT) begin
                    st_next.state = rbs_pkg::RBS_BOOT;
                    st_next.bus_wide = st_reg.wide_strap;
                    st_next.addr_size = st_reg.ext_code ? rbs_pkg::ADDR_SIZE_MAX : rbs_pkg::ADDR_SIZE_MIN;
                    if (st_reg.ext_code) begin
                        st_next.sel_a[rbs_pkg::DATA_PORT_LO] = rbs_pkg::SEL_ALL;
                        st_next.sel_b[rbs_pkg::DATA_PORT_LO] = rbs_pkg::SEL_ALL;
                        if (st_reg.wide_strap) begin
                            st_next.sel_a[rbs_pkg::DATA_PORT_HI] = rbs_pkg::SEL_ALL;
                            st_next.sel_b[rbs_pkg::DATA_PORT_HI] = rbs_pkg::SEL_ALL;
                        end
                    end
                end
            end
            rbs_pkg::RBS_BOOT: begin
                st_next.boot_req = 1'b1;
                st_next.state = rbs_pkg::RBS_RUN;
            end
            rbs_pkg::RBS_RUN: begin
                if (wr_en && paddr == rbs_pkg::OFF_PWR_CTRL) begin
                    if (pwdata[rbs_pkg::PC_PDOWN]) begin
                        st_next.state = rbs_pkg::RBS_PDOWN;
                    end else if (pwdata[rbs_pkg::PC_IDLE]) begin
                        st_next.state = rbs_pkg::RBS_IDLE;
                    end
                end
            end
            rbs_pkg::RBS_IDLE: begin
                if (wake_int || !eint_s[0] || !eint_s[1]) begin
                    st_next.state = rbs_pkg::RBS_RUN;
                end
            end
            rbs_pkg::RBS_PDOWN: begin
                // no register changes here: contents retained
                if (wake_int) begin
                    st_next.state = rbs_pkg::RBS_RUN;
                end
            end
            default: st_next.state = rbs_pkg::RBS_RESET;
        endcase

        // register writes only while the processor is running
        // an unmapped or unaligned address answers with an error and must leave every register alone
        if (wr_en && map_hit(paddr) && st_reg.state == rbs_pkg::RBS_RUN) begin
            if (paddr < rbs_pkg::OFF_SEL_B0) begin
                idx = paddr[4:2];
                st_next.sel_a[idx[1:0]] = pwdata[PW-1:0];
            end else if (paddr < rbs_pkg::OFF_BUS_CFG) begin
                idx = paddr[4:2];
                st_next.sel_b[idx[1:0]] = pwdata[PW-1:0];
            end else if (paddr == rbs_pkg::OFF_BUS_CFG) begin
                st_next.bus_wide = pwdata[rbs_pkg::BC_WIDE];
                if (pwdata[rbs_pkg::BC_ASZ_LSB +: 5] >= rbs_pkg::ADDR_SIZE_MIN
                    && pwdata[rbs_pkg::BC_ASZ_LSB +: 5] <= rbs_pkg::ADDR_SIZE_MAX) begin
                    st_next.addr_size = pwdata[rbs_pkg::BC_ASZ_LSB +: 5];
                end
            end else if (paddr == rbs_pkg::OFF_INT_CFG) begin
                st_next.int_cfg = pwdata[3:0];
            end
        end

        // read data captured in the setup phase
        if (rd_en) begin
            st_next.rdata = '0;
            if (paddr < rbs_pkg::OFF_SEL_B0) begin
                idx = paddr[4:2];
                st_next.rdata[PW-1:0] = st_reg.sel_a[idx[1:0]];
            end else if (paddr < rbs_pkg::OFF_BUS_CFG) begin
                idx = paddr[4:2];
                st_next.rdata[PW-1:0] = st_reg.sel_b[idx[1:0]];
            end else if (paddr == rbs_pkg::OFF_BUS_CFG) begin
                st_next.rdata[rbs_pkg::BC_WIDE] = st_reg.bus_wide;
                st_next.rdata[rbs_pkg::BC_ASZ_LSB +: 5] = st_reg.addr_size;
            end else if (paddr == rbs_pkg::OFF_STATUS) begin
                st_next.rdata[rbs_pkg::ST_EXT_CODE] = st_reg.ext_code;
                st_next.rdata[rbs_pkg::ST_WIDE_STRAP] = st_reg.wide_strap;
                st_next.rdata[rbs_pkg::ST_IDLE] = (st_reg.state == rbs_pkg::RBS_IDLE);
                st_next.rdata[rbs_pkg::ST_PDOWN] = (st_reg.state == rbs_pkg::RBS_PDOWN);
                st_next.rdata[rbs_pkg::ST_BOOT] = (st_reg.state == rbs_pkg::RBS_BOOT);
            end else if (paddr == rbs_pkg::OFF_INT_CFG) begin
                st_next.rdata[3:0] = st_reg.int_cfg;
            end
        end

        // a low reset pin reinitialises everything, the latched strap values included
        if (!rst_sync) begin
            st_next = '0;
            st_next.state = rbs_pkg::RBS_RESET;
            st_next.wide_strap = 1'b1;
            st_next.bus_wide = 1'b1;
            st_next.addr_size = rbs_pkg::ADDR_SIZE_MIN;
            for (int p = 0; p < NP; p++) begin
                st_next.sel_a[p] = rbs_pkg::SEL_A_RESET;
                st_next.sel_b[p] = rbs_pkg::SEL_B_RESET;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.state <= rbs_pkg::RBS_RESET;
            st_reg.wide_strap <= 1'b1;
            st_reg.bus_wide <= 1'b1;
            st_reg.addr_size <= rbs_pkg::ADDR_SIZE_MIN;
            st_reg.sel_a <= {NP{rbs_pkg::SEL_A_RESET}};
            st_reg.sel_b <= {NP{rbs_pkg::SEL_B_RESET}};
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    for (genvar p = 0; p < NP; p++) begin : g_port
        rbs_drive_decode u_dec (
            .sel_a(st_reg.sel_a[p]),
            .sel_b(st_reg.sel_b[p]),
            .open_drain(pin_open_drain[p*8 +: 8]),
            .quasi(pin_quasi[p*8 +: 8]),
            .hi_z(pin_hi_z[p*8 +: 8]),
            .push_pull(pin_push_pull[p*8 +: 8])
        );
    end

    // ram is never cleared here; its content after reset is whatever it was
    assign logic_reset_n = (st_reg.state != rbs_pkg::RBS_RESET) && (st_reg.state != rbs_pkg::RBS_STRAP);
    assign bus_width_pull_up = (st_reg.state == rbs_pkg::RBS_RESET) || (st_reg.state == rbs_pkg::RBS_STRAP);
    assign periph_run = (st_reg.state != rbs_pkg::RBS_PDOWN);
    assign core.ext_code = st_reg.ext_code;
    assign core.bus_wide = st_reg.bus_wide;
    assign core.addr_size = st_reg.addr_size;
    assign core.cpu_run = (st_reg.state == rbs_pkg::RBS_RUN) || (st_reg.state == rbs_pkg::RBS_BOOT);
    assign core.osc_run = (st_reg.state != rbs_pkg::RBS_PDOWN);
    assign core.boot_req = st_reg.boot_req;
    assign core.boot_vector_addr = rbs_pkg::RESET_VECTOR_ADDR;
    // after release the strap pin is the wait input; gated off until then
    assign core.bus_wait = logic_reset_n & strap_cs_s;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~map_hit(paddr);
    assign prdata = st_reg.rdata;
endmodule : rbs_top

// ---- rbs_top_properties.sv ----
// concurrent checks on the reset, strap and port-default block
`timescale 1ns/1ps
module rbs_top_properties (
    // clock and reset
    input logic pclk,
    input logic presetn,
    // board side
    input logic rst_pin_n,
    input logic code_source_strap,
    input logic bus_width_pull_up,
    // core side
    input rbs_pkg::rbs_core_t core,
    input logic logic_reset_n,
    input logic periph_run,
    // port drivers
    input logic [31:0] pin_open_drain,
    input logic [31:0] pin_quasi,
    input logic [31:0] pin_hi_z,
    input logic [31:0] pin_push_pull
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // driver modes and defaults
    // ----------------------------------------
    a_drive_one_hot: assert property (
        (pin_open_drain ^ pin_quasi ^ pin_hi_z ^ pin_push_pull) == 32'hffffffff
        && ((pin_open_drain & pin_quasi) | (pin_hi_z & pin_push_pull)) == 32'h00000000)
        else $error("pin driver mode not one-hot");
    a_default_quasi: assert property (
        $rose(logic_reset_n) && !core.ext_code |-> ##1 pin_quasi == 32'hffffffff)
        else $error("internal-code boot left a pin off quasi mode");
    a_ext_push_pull: assert property (
        $rose(logic_reset_n) && core.ext_code |-> ##1 pin_push_pull[7:0] == 8'hff && pin_quasi[15:8] == 8'hff
        && pin_push_pull[23:16] == (core.bus_wide ? 8'hff : 8'h00))
        else $error("external-code boot data bus drivers wrong");
    a_addr_size_boot: assert property (
        $rose(logic_reset_n) |-> ##1 core.addr_size == (core.ext_code ? 5'h14 : 5'h0c))
        else $error("boot address size wrong");
    // ----------------------------------------
    // reset sequencing
    // ----------------------------------------
    a_pin_reset_hold: assert property (
        !rst_pin_n [*6] |-> !logic_reset_n)
        else $error("held reset pin did not reset the logic");
    a_release_order: assert property (
        $rose(rst_pin_n) |-> !logic_reset_n [*4] ##[1:8] logic_reset_n)
        else $error("logic reset release out of window");
    a_boot_pulse: assert property (
        $rose(logic_reset_n) |-> ##1 core.boot_req && core.boot_vector_addr == 16'h0000 ##1 !core.boot_req)
        else $error("boot request not a single pulse at vector zero");
    a_pull_up_reset: assert property (
        bus_width_pull_up == !logic_reset_n)
        else $error("strap pull-up not following reset");
    a_wait_input: assert property (
        $stable(code_source_strap) [*6] ##0 (core.cpu_run && logic_reset_n && !core.boot_req)
        |-> core.bus_wait == code_source_strap)
        else $error("bus wait does not follow the strap pin");
    // ----------------------------------------
    // power modes
    // ----------------------------------------
    a_pdown_stops: assert property (
        logic_reset_n && !core.osc_run |-> !periph_run && !core.cpu_run)
        else $error("power-down left something running");
    a_idle_periph: assert property (
        logic_reset_n && core.osc_run |-> periph_run)
        else $error("peripherals stopped outside power-down");
    a_pdown_frozen: assert property (
        !core.osc_run && !$past(core.osc_run) && logic_reset_n && $past(logic_reset_n)
        |-> $stable(pin_push_pull) && $stable(pin_quasi) && $stable(core.addr_size))
        else $error("state changed during power-down");
endmodule : rbs_top_properties

bind rbs_top rbs_top_properties rbs_top_properties_inst (.*);

// ---- rbs_board.sv ----
// board reset circuit and strap resistors facing the block
`timescale 1ns/1ps
module rbs_board (
    // clock
    input logic pclk,
    // weak pull-up enable from the block
    input logic bus_width_pull_up,
    // board pins
    output logic rst_pin_n,
    output logic code_source_strap,
    output logic bus_width_strap
);
    logic narrow = 1'b0;
    logic wait_level = 1'b0;
    logic bw_level = 1'b1;
    initial rst_pin_n = 1'b0;
    initial code_source_strap = 1'b1;
    // a resistor to ground wins; with no resistor and no pull-up the pin wanders
    always @(posedge pclk) bw_level <= narrow ? 1'b0 : (bus_width_pull_up ? 1'b1 : ~bw_level);
    assign bus_width_strap = bw_level;
    task automatic pin_reset(input logic ext, input logic nar, input int low_cyc);
        narrow <= nar;
        code_source_strap <= ~ext;
        rst_pin_n <= 1'b0;
        repeat (low_cyc) @(posedge pclk);
        rst_pin_n <= 1'b1;
        repeat (rbs_pkg::STRAP_HOLD_CYC) @(posedge pclk);
        code_source_strap <= wait_level;
    endtask : pin_reset
    task automatic set_wait(input logic v);
        wait_level = v;
        code_source_strap <= v;
    endtask : set_wait
endmodule : rbs_board

// ---- rbs_top_tb.sv ----
// self-checking bench for the reset, strap and port-default block
`timescale 1ns/1ps
module rbs_top_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [1:0] ext_int_n = 2'h3;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic rst_pin_n, code_source_strap, bus_width_strap, bus_width_pull_up, pready, pslverr, logic_reset_n, periph_run;
    logic [31:0] prdata, pin_open_drain, pin_quasi, pin_hi_z, pin_push_pull, q;
    logic e;
    rbs_pkg::rbs_core_t core;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] cfg_in [5] = '{32'h00001000, 32'h00001500, 32'h00000b00, 32'h00001401, 32'h00000c00};
    logic [31:0] cfg_exp [5] = '{32'h00001000, 32'h00001000, 32'h00001000, 32'h00001401, 32'h00000c00};
    always #50 pclk = ~pclk;
    rbs_top rbs_top_inst (.*);
    rbs_board rbs_board_inst (.*);
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // this wait ends once pready is seen high, or at the bench timeout
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(q & mask, exp);
    endtask : rd
    task automatic pins(input int p, input logic [7:0] b, input logic [7:0] a);
        for (int i = 0; i < 8; i++) begin
            check(32'({pin_push_pull[p*8+i], pin_hi_z[p*8+i], pin_quasi[p*8+i], pin_open_drain[p*8+i]}),
                32'(4'h1 << {b[i], a[i]}));
        end
    endtask : pins
    task automatic wait_run(input logic osc);
        for (int n = 0; n < 20 && (osc ? core.osc_run : core.cpu_run) !== 1'b1; n++) @(posedge pclk);
    endtask : wait_run
    task automatic boot(input logic ext, input logic nar, input int low_cyc);
        rbs_board_inst.pin_reset(ext, nar, low_cyc);
        for (int n = 0; n < 100 && logic_reset_n !== 1'b1; n++) @(posedge pclk);
        check(32'(logic_reset_n), 32'h1);
        repeat (3) @(posedge pclk);
        check(32'(core.ext_code), 32'(ext));
        check(32'(core.addr_size), ext ? 32'h14 : 32'h0c);
    endtask : boot
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            conclude();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        boot(1'b0, 1'b0, 200);
        rd(rbs_pkg::OFF_STATUS, 32'h3, 32'h2);
        rd(rbs_pkg::OFF_BUS_CFG, 32'hffffffff, 32'h00000c01);
        for (int p = 0; p < 4; p++) begin
            rd(rbs_pkg::OFF_SEL_A0 + 12'(4 * p), 32'hffffffff, 32'h000000ff);
            rd(rbs_pkg::OFF_SEL_B0 + 12'(4 * p), 32'hffffffff, 32'h00000000);
            pins(p, 8'h00, 8'hff);
        end
        wr(rbs_pkg::OFF_SEL_B0 + 12'h004, 32'h000000a6);
        wr(rbs_pkg::OFF_SEL_A0 + 12'h004, 32'h000000ca);
        pins(1, 8'ha6, 8'hca);
        pins(0, 8'h00, 8'hff);
        rd(rbs_pkg::OFF_SEL_B0 + 12'h004, 32'hffffffff, 32'h000000a6);
        wr(rbs_pkg::OFF_SEL_A0 + 12'h00c, 32'hffffff33);
        rd(rbs_pkg::OFF_SEL_A0 + 12'h00c, 32'hffffffff, 32'h00000033);
        apb(1'b0, 12'h030, 32'h00000000);
        check(32'(e), 32'h1);
        apb(1'b1, 12'h100, 32'h000000ff);
        check(32'(e), 32'h1);
        apb(1'b1, 12'h005, 32'h00000000);
        check(32'(e), 32'h1);
        for (int k = 0; k < 5; k++) begin
            wr(rbs_pkg::OFF_BUS_CFG, cfg_in[k]);
            rd(rbs_pkg::OFF_BUS_CFG, 32'hffffffff, cfg_exp[k]);
        end
        check(32'({core.bus_wide, core.addr_size}), 32'h0c);
        rbs_board_inst.set_wait(1'b1);
        repeat (8) @(posedge pclk);
        check(32'(core.bus_wait), 32'h1);
        rbs_board_inst.set_wait(1'b0);
        repeat (8) @(posedge pclk);
        check(32'(core.bus_wait), 32'h0);
        wr(rbs_pkg::OFF_PWR_CTRL, 32'h00000001);
        check(32'({core.cpu_run, core.osc_run, periph_run}), 32'h3);
        rd(rbs_pkg::OFF_STATUS, 32'h4, 32'h4);
        ext_int_n <= 2'h1;
        wait_run(1'b0);
        check(32'(core.cpu_run), 32'h1);
        ext_int_n <= 2'h3;
        wr(rbs_pkg::OFF_INT_CFG, 32'h00000001);
        wr(rbs_pkg::OFF_PWR_CTRL, 32'h00000002);
        check(32'({core.osc_run, periph_run}), 32'h0);
        ext_int_n <= 2'h2;
        repeat (10) @(posedge pclk);
        check(32'(core.osc_run), 32'h0);
        rd(rbs_pkg::OFF_SEL_A0 + 12'h004, 32'hffffffff, 32'h000000ca);
        rd(rbs_pkg::OFF_STATUS, 32'h8, 32'h8);
        ext_int_n <= 2'h3;
        boot(1'b1, 1'b1, 100);
        rd(rbs_pkg::OFF_STATUS, 32'h3, 32'h1);
        rd(rbs_pkg::OFF_SEL_A0 + 12'h004, 32'hffffffff, 32'h000000ff);
        pins(0, 8'hff, 8'hff);
        pins(2, 8'h00, 8'hff);
        wr(rbs_pkg::OFF_INT_CFG, 32'h00000005);
        wr(rbs_pkg::OFF_PWR_CTRL, 32'h00000002);
        ext_int_n <= 2'h2;
        wait_run(1'b1);
        check(32'(core.osc_run), 32'h1);
        ext_int_n <= 2'h3;
        boot(1'b1, 1'b0, 100);
        pins(2, 8'hff, 8'hff);
        conclude();
    end
endmodule : rbs_top_tb
